/* File: logic/ebtc_pkg.sv */
// constants for the eight bit timer with compare channel
package ebtc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_COUNT  = 8'h04;
	localparam logic [7:0] OFS_COMP   = 8'h08;
	localparam logic [7:0] OFS_FLAG   = 8'h0c;
	localparam logic [7:0] OFS_MASK   = 8'h10;
	localparam logic [7:0] OFS_ASYNC  = 8'h14;
	// control register fields
	localparam int CS_LSB    = 0;
	localparam int WGM_LO    = 3;
	localparam int WGM_HI    = 4;
	localparam int COM_LSB   = 5;
	localparam int FOC_BIT   = 7;
	// flag and mask fields
	localparam int OVF_BIT   = 0;
	localparam int CMP_BIT   = 1;
	// async status field
	localparam int ASEL_BIT  = 3;
	// reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] COMP_RST  = 8'h00;
	// counter extremes
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;
	// prescaler divide masks, a tick when the masked bits are all ones
	localparam logic [9:0] DIV8    = 10'h007;
	localparam logic [9:0] DIV32   = 10'h01f;
	localparam logic [9:0] DIV64   = 10'h03f;
	localparam logic [9:0] DIV128  = 10'h07f;
	localparam logic [9:0] DIV256  = 10'h0ff;
	localparam logic [9:0] DIV1024 = 10'h3ff;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// waveform modes
	typedef enum logic [1:0] {
		ebtc_normal = 2'h0,
		ebtc_pcpwm  = 2'h1,
		ebtc_ctc    = 2'h2,
		ebtc_fpwm   = 2'h3
	} ebtc_mode_t;
endpackage : ebtc_pkg

/* File: logic/ebtc_top.sv */
// eight bit timer with one compare channel behind an axi4-lite slave
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module ebtc_top (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        osc_pin_in,
	output logic             osc_pin_out,
	input  wire logic        ovf_irq_ack,
	input  wire logic        cmp_irq_ack,
	output logic             ovf_irq,
	output logic             cmp_irq,
	output logic             compare_output
);
	import ebtc_pkg::*;

	// bus state
	logic        aw_ff, w_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic        wen_ff;
	logic        bvalid_ff, rvalid_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	// registers
	logic [7:0]  ctrl_ff;
	logic [7:0]  counter_value_ff;
	logic [7:0]  compare_value_reg_ff;
	logic [7:0]  compare_buf_ff;
	logic [1:0]  timer_flag_reg_ff;
	logic [1:0]  timer_mask_reg_ff;
	logic        async_clock_select_ff;
	// timer state
	logic        osc_s1_ff, osc_s2_ff, osc_s3_ff;
	logic [9:0]  presc_ff;
	logic        down_ff;
	logic        block_ff;
	logic        oc_ff;
	logic        osc_out_ff;
	logic        ovf_irq_ff, cmp_irq_ff;

	// write decode
	wire         wr_go      = aw_ff && w_ff && !bvalid_ff;
	wire         wr_ok      = wr_go && wen_ff;
	wire         wr_ctrl    = wr_ok && awaddr_ff == OFS_CTRL;
	wire         wr_count   = wr_ok && awaddr_ff == OFS_COUNT;
	wire         wr_comp    = wr_ok && awaddr_ff == OFS_COMP;
	wire         wr_flag    = wr_ok && awaddr_ff == OFS_FLAG;
	wire         wr_mask    = wr_ok && awaddr_ff == OFS_MASK;
	wire         wr_async   = wr_ok && awaddr_ff == OFS_ASYNC;
	wire         wr_mapped  = awaddr_ff == OFS_CTRL || awaddr_ff == OFS_COUNT
		|| awaddr_ff == OFS_COMP || awaddr_ff == OFS_FLAG
		|| awaddr_ff == OFS_MASK || awaddr_ff == OFS_ASYNC;
	wire  [7:0]  wbyte      = wdata_ff[7:0];
	wire         rd_go      = s_axi_arvalid && !rvalid_ff;
	wire         rd_mapped  = s_axi_araddr == OFS_CTRL
		|| s_axi_araddr == OFS_COUNT || s_axi_araddr == OFS_COMP
		|| s_axi_araddr == OFS_FLAG || s_axi_araddr == OFS_MASK
		|| s_axi_araddr == OFS_ASYNC;

	// field selection
	wire  [2:0]  clock_select_field = ctrl_ff[CS_LSB +: 3];
	wire         waveform_mode_lo   = ctrl_ff[WGM_LO];
	wire         waveform_mode_hi   = ctrl_ff[WGM_HI];
	wire  [1:0]  compare_output_mode = ctrl_ff[COM_LSB +: 2];
	wire         force_compare_strobe = wr_ctrl && wbyte[FOC_BIT]
		&& !wbyte[WGM_LO];
	wire  [1:0]  oc_com     = force_compare_strobe ? wbyte[COM_LSB +: 2]
		: compare_output_mode;
	ebtc_mode_t  mode;
	assign mode = ebtc_mode_t'({waveform_mode_hi, waveform_mode_lo});
	wire         pwm_mode   = mode == ebtc_pcpwm || mode == ebtc_fpwm;

	// clock source and prescaler
	wire         osc_rise   = osc_s2_ff && !osc_s3_ff;
	wire         src_tick   = async_clock_select_ff ? osc_rise : 1'b1;
	logic        presc_hit;
	always_comb begin
		unique case (clock_select_field)
		3'h1:    presc_hit = 1'b1;
		3'h2:    presc_hit = (presc_ff & DIV8) == DIV8;
		3'h3:    presc_hit = (presc_ff & DIV32) == DIV32;
		3'h4:    presc_hit = (presc_ff & DIV64) == DIV64;
		3'h5:    presc_hit = (presc_ff & DIV128) == DIV128;
		3'h6:    presc_hit = (presc_ff & DIV256) == DIV256;
		3'h7:    presc_hit = (presc_ff & DIV1024) == DIV1024;
		default: presc_hit = 1'b0;
		endcase
	end
	wire         tick       = src_tick && presc_hit;

	// counter unit
	wire         at_bottom  = counter_value_ff == CNT_BOTTOM;
	wire         at_max     = counter_value_ff == CNT_MAX;
	wire         match      = counter_value_ff == compare_value_reg_ff
		&& !block_ff;
	wire  [7:0]  top_val    = mode == ebtc_ctc ? compare_value_reg_ff
		: CNT_MAX;
	logic [7:0]  nxt_counter_value;
	logic        nxt_down;
	logic        ovf_evt;
	always_comb begin
		nxt_counter_value = counter_value_ff + 8'h01;
		nxt_down = down_ff;
		ovf_evt = 1'b0;
		unique case (mode)
		ebtc_ctc: begin
			if (match) begin
				nxt_counter_value = CNT_BOTTOM;
			end
			ovf_evt = at_max;
		end
		ebtc_pcpwm: begin
			if (down_ff) begin
				nxt_counter_value = counter_value_ff - 8'h01;
			end
			if (at_max) begin
				nxt_down = 1'b1;
				nxt_counter_value = counter_value_ff - 8'h01;
			end else if (at_bottom && down_ff) begin
				nxt_down = 1'b0;
				nxt_counter_value = counter_value_ff + 8'h01;
				ovf_evt = 1'b1;
			end
		end
		default: begin
			ovf_evt = counter_value_ff == top_val;
		end
		endcase
	end

	// double buffer update point
	wire         upd_pt     = mode == ebtc_fpwm ? at_max
		: at_max && !down_ff;

	// waveform generator
	logic        nxt_oc;
	always_comb begin
		nxt_oc = oc_ff;
		if (!pwm_mode || force_compare_strobe) begin
			if ((tick && match) || force_compare_strobe) begin
				unique case (oc_com)
				2'h1:    nxt_oc = !oc_ff;
				2'h2:    nxt_oc = 1'b0;
				2'h3:    nxt_oc = 1'b1;
				default: nxt_oc = oc_ff;
				endcase
			end
		end else if (tick && compare_output_mode[1]) begin
			if (mode == ebtc_fpwm) begin
				if (match) begin
					nxt_oc = compare_output_mode[0];
				end else if (at_max) begin
					nxt_oc = !compare_output_mode[0];
				end
			end else if (match) begin
				nxt_oc = compare_output_mode[0] ^ down_ff;
			end
		end
	end

	// read mux
	logic [7:0]  rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		unique case (s_axi_araddr)
		OFS_CTRL:  rd_byte = {1'b0, ctrl_ff[6:0]};
		OFS_COUNT: rd_byte = counter_value_ff;
		OFS_COMP:  rd_byte = compare_buf_ff;
		OFS_FLAG:  rd_byte = {6'h00, timer_flag_reg_ff};
		OFS_MASK:  rd_byte = {6'h00, timer_mask_reg_ff};
		OFS_ASYNC: rd_byte = {4'h0, async_clock_select_ff, 3'h0};
		default:   rd_byte = 8'h00;
		endcase
	end

	wire         ovf_set    = tick && !wr_count && ovf_evt;
	wire         cmp_set    = tick && match;
	wire  [1:0]  flag_clr   = (wr_flag ? wbyte[1:0] : 2'h0)
		| {cmp_irq_ack, ovf_irq_ack};
	wire  [1:0]  flag_set   = {cmp_set, ovf_set};

	// axi write channel
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wen_ff <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_ff) begin
				aw_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_ff <= 1'b0;
			end
			if (s_axi_wvalid && !w_ff) begin
				w_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wen_ff <= s_axi_wstrb[0];
			end else if (wr_go) begin
				w_ff <= 1'b0;
			end
		end
	end

	// axi responses
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else begin
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
			if (rd_go) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
				rdata_ff <= {24'h00_0000, rd_byte};
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= CTRL_RST;
			timer_mask_reg_ff <= 2'h0;
			async_clock_select_ff <= 1'b0;
			compare_buf_ff <= COMP_RST;
			compare_value_reg_ff <= COMP_RST;
			timer_flag_reg_ff <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= {1'b0, wbyte[6:0]};
			end
			if (wr_mask) begin
				timer_mask_reg_ff <= wbyte[1:0];
			end
			if (wr_async) begin
				async_clock_select_ff <= wbyte[ASEL_BIT];
			end
			if (wr_comp) begin
				compare_buf_ff <= wbyte;
			end
			if (wr_comp && !pwm_mode) begin
				compare_value_reg_ff <= wbyte;
			end else if (!pwm_mode) begin
				compare_value_reg_ff <= compare_buf_ff;
			end else if (tick && upd_pt) begin
				compare_value_reg_ff <= compare_buf_ff;
			end
			timer_flag_reg_ff <= (timer_flag_reg_ff & ~flag_clr)
				| flag_set;
		end
	end

	// counter and waveform state
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			counter_value_ff <= COUNT_RST;
			down_ff <= 1'b0;
			block_ff <= 1'b0;
			oc_ff <= 1'b0;
			presc_ff <= 10'h000;
		end else begin
			if (src_tick) begin
				presc_ff <= presc_ff + 10'h001;
			end
			if (wr_count) begin
				counter_value_ff <= wbyte;
				block_ff <= 1'b1;
			end else if (tick) begin
				counter_value_ff <= nxt_counter_value;
				down_ff <= mode == ebtc_pcpwm ? nxt_down : 1'b0;
				block_ff <= 1'b0;
			end
			oc_ff <= nxt_oc;
		end
	end

	// oscillator synchroniser and outputs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			osc_s1_ff <= 1'b0;
			osc_s2_ff <= 1'b0;
			osc_s3_ff <= 1'b0;
			osc_out_ff <= 1'b0;
			ovf_irq_ff <= 1'b0;
			cmp_irq_ff <= 1'b0;
		end else begin
			osc_s1_ff <= osc_pin_in;
			osc_s2_ff <= osc_s1_ff;
			osc_s3_ff <= osc_s2_ff;
			osc_out_ff <= async_clock_select_ff && !osc_s2_ff;
			ovf_irq_ff <= timer_flag_reg_ff[OVF_BIT]
				&& timer_mask_reg_ff[OVF_BIT] && !ovf_irq_ack;
			cmp_irq_ff <= timer_flag_reg_ff[CMP_BIT]
				&& timer_mask_reg_ff[CMP_BIT] && !cmp_irq_ack;
		end
	end

	assign s_axi_awready  = !aw_ff;
	assign s_axi_wready   = !w_ff;
	assign s_axi_bvalid   = bvalid_ff;
	assign s_axi_bresp    = bresp_ff;
	assign s_axi_arready  = !rvalid_ff;
	assign s_axi_rvalid   = rvalid_ff;
	assign s_axi_rresp    = rresp_ff;
	assign s_axi_rdata    = rdata_ff;
	assign osc_pin_out    = osc_out_ff;
	assign ovf_irq        = ovf_irq_ff;
	assign cmp_irq        = cmp_irq_ff;
	assign compare_output = oc_ff;
endmodule : ebtc_top

/* File: testbench/ebtc_osc_model.sv */
// crystal oscillator model on the asynchronous timer pin
`timescale 1ns/1ps
module ebtc_osc_model (
	input  wire logic run,
	output logic      osc
);
	// pin rests low outside a burst
	initial osc = 1'b0;
	always begin
		wait (run === 1'b1);
		#103 osc = 1'b1;
		#97 osc = 1'b0;
	end
endmodule : ebtc_osc_model

/* File: testbench/ebtc_properties.sv */
// bus and interrupt properties of the timer block
`timescale 1ns/1ps
module ebtc_properties (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        ovf_irq_ack,
	input wire logic        ovf_irq,
	input wire logic        cmp_irq_ack,
	input wire logic        cmp_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr;
		s_wr |-> ##[1:3] s_axi_bvalid;
	endproperty
	property p_rd;
		s_rd |=> s_axi_rvalid;
	endproperty
	property p_bd;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	property p_bz;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	property p_ref;
		s_wr |=> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_ar;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_oa;
		ovf_irq && ovf_irq_ack |=> !ovf_irq;
	endproperty
	property p_ca;
		cmp_irq && cmp_irq_ack |=> !cmp_irq;
	endproperty
	a_wr: assert property (p_wr) else $error("write not answered");
	a_rd: assert property (p_rd) else $error("read not answered");
	a_bd: assert property (p_bd) else $error("response held");
	a_bz: assert property (p_bz) else $error("upper read bits set");
	a_ref: assert property (p_ref) else $error("write not held");
	a_ar: assert property (p_ar) else $error("read taken early");
	a_oa: assert property (p_oa) else $error("overflow irq stuck");
	a_ca: assert property (p_ca) else $error("compare irq stuck");
endmodule : ebtc_properties
bind ebtc_top ebtc_properties i_ebtc_properties (.*);

/* File: testbench/tb.sv */
// self-checking bench for the timer block
`timescale 1ns/1ps
module tb;
	import ebtc_pkg::*;
	logic        mclk, rst, osc_pin_in, osc_pin_out, compare_output;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, v;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, ovf_irq, cmp_irq, o;
	logic        ovf_irq_ack, cmp_irq_ack, osc_run;
	logic [33:0] exp_q[$];
	logic [33:0] ex;
	int          failures, n_checks, cyc, n_osc, seed, i;

	ebtc_top i_ebtc_top (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_pin_in,
		.osc_pin_out, .ovf_irq_ack, .cmp_irq_ack, .ovf_irq, .cmp_irq,
		.compare_output);
	ebtc_osc_model i_ebtc_osc_model (.run(osc_run), .osc(osc_pin_in));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r = RESP_OKAY);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r = RESP_OKAY);
		exp_q.push_back({r, 24'h000000, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
	endtask : rd

	// read answers are matched against the oldest expectation
	always @(posedge mclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			ex = exp_q.pop_front();
			chk({s_axi_rresp, s_axi_rdata}, ex);
		end
	end

	always @(posedge osc_pin_in) n_osc++;

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		{failures, n_checks, cyc, n_osc} = '0;
		seed = 75;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{ovf_irq_ack, cmp_irq_ack, osc_run} = '0;
		s_axi_wstrb = 4'hf;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		rst = 1'b1;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk(osc_pin_out, 34'h0);
		wr(8'h18, 8'h55, RESP_SLVERR);
		for (i = 0; i < 7; i++)
			rd(8'(i * 4), 8'h00, (i == 6) ? RESP_SLVERR : RESP_OKAY);
		wr(OFS_COMP, 8'h03);
		rd(OFS_COMP, 8'h03);
		wr(OFS_MASK, 8'h02);
		wr(OFS_CTRL, 8'h11);
		while (cmp_irq !== 1'b1) @(posedge mclk);
		rd(OFS_FLAG, 8'h02);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_FLAG, 8'h00);
		rd(OFS_FLAG, 8'h02);
		cmp_irq_ack <= 1'b1;
		@(posedge mclk);
		cmp_irq_ack <= 1'b0;
		@(posedge mclk);
		chk(cmp_irq, 34'h0);
		wr(OFS_MASK, 8'h01);
		wr(OFS_CTRL, 8'h01);
		while (ovf_irq !== 1'b1) @(posedge mclk);
		chk(cmp_irq, 34'h0);
		ovf_irq_ack <= 1'b1;
		@(posedge mclk);
		ovf_irq_ack <= 1'b0;
		@(posedge mclk);
		chk(ovf_irq, 34'h0);
		wr(OFS_CTRL, 8'h00);
		v = 8'h10 + 8'($random(seed) & 8'h7f);
		wr(OFS_COUNT, v);
		wr(OFS_COMP, v);
		wr(OFS_FLAG, 8'h03);
		rd(OFS_FLAG, 8'h00);
		o = compare_output;
		wr(OFS_CTRL, 8'ha0);
		repeat (2) @(posedge mclk);
		chk(compare_output, {33'h0, ~o});
		rd(OFS_COUNT, v);
		rd(OFS_FLAG, 8'h00);
		wr(OFS_CTRL, 8'h21);
		rd(OFS_FLAG, 8'h00);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_COUNT, 8'h00);
		wr(OFS_ASYNC, 8'h08);
		rd(OFS_ASYNC, 8'h08);
		chk(osc_pin_out, 34'h1);
		wr(OFS_CTRL, 8'h01);
		n_osc = 0;
		osc_run <= 1'b1;
		repeat (100) @(posedge mclk);
		osc_run <= 1'b0;
		repeat (20) @(posedge mclk);
		rd(OFS_COUNT, 8'(n_osc));
		wr(OFS_CTRL, 8'h00);
		wr(OFS_ASYNC, 8'h00);
		wr(OFS_COUNT, 8'h00);
		wr(OFS_COMP, 8'h80);
		wr(OFS_CTRL, 8'h59);
		while (compare_output !== 1'b0) @(posedge mclk);
		while (compare_output !== 1'b1) @(posedge mclk);
		i = 0;
		while (compare_output === 1'b1) begin
			@(posedge mclk);
			i++;
		end
		chk(i, 34'd129);
		chk(osc_pin_out, 34'h0);
		wr(OFS_COMP, 8'h40);
		rd(OFS_COMP, 8'h40);
		while (compare_output !== 1'b1) @(posedge mclk);
		i = 0;
		while (compare_output === 1'b1) begin
			@(posedge mclk);
			i++;
		end
		chk(i, 34'd65);
		end_of_test();
	end
endmodule : tb
